// *** design/tbf_crc.sv ***
/*
  Byte-wide CRC over the reflected proximity-card polynomial.
  Assumes one byte offered per cycle at most. Init together with step folds
  the byte into a fresh preset, so a frame's first byte is never lost.
*/
`timescale 1ns/100ps
`include "tbf_defines.svh"
module tbf_crc
  import tbf_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Control and data
  input wire logic init,
  input wire logic step,
  input wire logic [7:0] data,
  // Result
  output logic [15:0] crc
);
  typedef struct packed {
    logic [15:0] crc;
  } tbf_crc_st_t;

  tbf_crc_st_t s_q, s_d;

  always_comb begin
    logic [15:0] c;
    c = init ? `TBF_CRC_PRESET : s_q.crc;
    s_d = s_q;
    if (step) begin
      c = c ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
        c = c[0] ? ((c >> 1) ^ `TBF_CRC_POLY) : (c >> 1);
      end
    end
    s_d.crc = c;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{crc: `TBF_CRC_PRESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign crc = s_q.crc;
endmodule // tbf_crc

// *** design/tbf_defines.svh ***
/*
  Constants for the answer framer and attribute parser: codes, field
  positions and fixed values. Assumes inclusion by bare name.
*/
`ifndef TBF_DEFINES_SVH
`define TBF_DEFINES_SVH
`define TBF_ANSWER_CODE 8'h50
`define TBF_ATTRIB_CODE 8'h1D
`define TBF_APP_DATA 32'h0000_0000
`define TBF_PROTO1 8'h91
`define TBF_FRAME_SIZE_CODE 4'h8
`define TBF_PROTO_TYPE 4'h1
`define TBF_ADC_CODE 2'h0
`define TBF_FO_CODE 2'h0
`define TBF_ANSWER_LEN 4'hE
`define TBF_ATTRIB_LEN 4'hB
`define TBF_CRC_PRESET 16'hFFFF
`define TBF_CRC_POLY 16'h8408
`define TBF_CRC_RESIDUE 16'hF0B8
`define TBF_TR0_FIELD_HI 7
`define TBF_TR1_FIELD_HI 5
`define TBF_TIMING_RSVD 2'h3
`define TBF_MIN_TR0_FS 8'h40
`define TBF_MIN_TR1_FS 8'h50
`define TBF_TR2_ETU 10
`define TBF_TR2_FS 32
`endif

// *** design/tbf_framer.sv ***
/*
  Answer frame builder and attribute command parser for a proximity tag.
  Assumes the receive path hands over deframed bytes with a last flag and
  the transmit path takes bytes under a valid/ready handshake.
*/
// Contract
// - The answer is code 0x50, four identifier bytes, four application bytes, three protocol bytes, two CRC bytes.
// - The four application bytes are all zero and carry no vendor content.
// - The first protocol byte is 0x91 for 106 and 212 kbps with equal rates.
// - The second protocol byte is 0x81 whose upper nibble 1000b gives a 256-byte frame.
// - The lower nibble of the second protocol byte is protocol type 0001b.
// - The third protocol byte carries the waiting-time integer high and zeros low.
// - Bits 3-2 of the third protocol byte are 00b for vendor coding.
// - Bits 1-0 of the third protocol byte are 00b for no node address or number.
// - An attribute command with code 0x1D and the matching identifier enables command processing.
// - Bits 1-0 of the first parameter are ignored and a reserved 11b timing field reads as 00b.
// - The tag always uses 64 and 80 subcarrier periods and never omits its delimiters.
`timescale 1ns/100ps
`include "tbf_defines.svh"
module tbf_framer
  import tbf_pkg::*;
#(
  parameter int ID_BYTES = 4
)(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Configuration
  input wire logic [31:0] card_id,
  input wire logic [3:0] fwi,
  // Answer request from the command decoder
  input wire logic answer_req,
  // Received command bytes
  input wire tbf_byte_t rx,
  // Transmit bytes
  output tbf_byte_t tx,
  input wire logic tx_ready,
  // Results
  output logic cmd_enabled,
  output logic attrib_ok,
  output tbf_param1_t param1,
  output logic [7:0] min_tr0_fs,
  output logic [7:0] min_tr1_fs,
  output logic sof_omit,
  output logic eof_omit,
  output logic busy
);
  typedef struct packed {
    tbf_state_t st;
    logic [3:0] idx;
    logic [7:0] txd;
    logic txv;
    logic txl;
    logic [31:0] rid;
    logic [7:0] p1;
    logic match;
    logic en;
    logic ok;
    logic pend;
    tbf_param1_t prm;
  } tbf_st_t;

  tbf_st_t s_q, s_d;
  logic [15:0] crc;
  logic crc_init, crc_step;
  logic [7:0] crc_data;
  logic [7:0] proto2, proto3;
  logic [1:0] tr0_raw, tr1_raw;
  logic tx_take;

  assign proto2 = {`TBF_FRAME_SIZE_CODE, `TBF_PROTO_TYPE};
  assign proto3 = {fwi, `TBF_ADC_CODE, `TBF_FO_CODE};
  assign tx_take = s_q.txv && tx_ready;
  assign tr0_raw = s_q.p1[`TBF_TR0_FIELD_HI -: 2];
  assign tr1_raw = s_q.p1[`TBF_TR1_FIELD_HI -: 2];

  // Byte at a given answer position; CRC bytes come from the running CRC.
  function automatic logic [7:0] answer_byte(input logic [3:0] i, input logic [15:0] c);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      4'h0: b = `TBF_ANSWER_CODE;
      4'h1, 4'h2, 4'h3, 4'h4: b = card_id[8 * (4 - i) +: 8];
      4'h5, 4'h6, 4'h7, 4'h8: b = 8'(`TBF_APP_DATA >> (8 * (8 - i)));
      4'h9: b = `TBF_PROTO1;
      4'hA: b = proto2;
      4'hB: b = proto3;
      4'hC: b = ~c[7:0];
      4'hD: b = ~c[15:8];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  always_comb begin
    s_d = s_q;
    crc_init = 1'b0;
    crc_step = 1'b0;
    crc_data = 8'h00;
    s_d.ok = 1'b0;
    s_d.pend = 1'b0;
    case (s_q.st)
      TBF_IDLE: begin
        if (answer_req) begin
          crc_init = 1'b1;
          s_d.st = TBF_SEND;
          s_d.idx = 4'h0;
          s_d.txd = `TBF_ANSWER_CODE;
          s_d.txv = 1'b1;
          s_d.txl = 1'b0;
        end else if (rx.valid) begin
          crc_init = 1'b1;
          crc_step = 1'b1;
          crc_data = rx.data;
          s_d.st = rx.last ? TBF_IDLE : TBF_RECV;
          s_d.idx = 4'h1;
          s_d.match = (rx.data == `TBF_ATTRIB_CODE) && !rx.last;
        end
      end
      TBF_SEND: begin
        if (tx_take) begin
          if (s_q.idx < 4'hC) begin
            crc_step = 1'b1;
            crc_data = s_q.txd;
          end
          if (s_q.txl) begin
            s_d.st = TBF_IDLE;
            s_d.txv = 1'b0;
            s_d.txl = 1'b0;
          end else begin
            s_d.idx = s_q.idx + 4'h1;
            s_d.txl = (s_q.idx + 4'h1) == (`TBF_ANSWER_LEN - 4'h1);
          end
        end
        // The CRC low byte waits one empty cycle until the last protocol byte has been folded in.
        if (s_q.idx == 4'hC && !s_q.txv) begin
          s_d.txd = answer_byte(4'hC, crc);
          s_d.txv = 1'b1;
        end else if (!tx_take || s_q.txl) begin
          s_d.txd = s_q.txd;
        end else if (s_q.idx + 4'h1 == 4'hC) begin
          s_d.txd = 8'h00;
          s_d.txv = 1'b0;
        end else begin
          s_d.txd = answer_byte(s_q.idx + 4'h1, crc);
        end
      end
      TBF_RECV: begin
        if (rx.valid) begin
          crc_step = 1'b1;
          crc_data = rx.data;
          if (s_q.idx >= 4'h1 && s_q.idx <= 4'h4) begin
            s_d.rid = {s_q.rid[23:0], rx.data};
          end
          if (s_q.idx == 4'h5) begin
            s_d.p1 = rx.data;
          end
          if (s_q.idx != 4'hF) begin
            s_d.idx = s_q.idx + 4'h1;
          end
          if (rx.last) begin
            s_d.st = TBF_IDLE;
          end
        end
      end
      default: s_d.st = TBF_IDLE;
    endcase
    if (s_q.st == TBF_RECV && rx.valid && rx.last) begin
      // Code, length and identifier are settled now; the CRC residue is only known a cycle later.
      if (s_q.match && s_q.idx == `TBF_ATTRIB_LEN - 4'h1 && s_q.rid == card_id) begin
        s_d.pend = 1'b1;
      end
    end
    // Residue of a good frame after feeding its own CRC bytes is a fixed constant.
    if (s_q.pend && crc == `TBF_CRC_RESIDUE) begin
      s_d.ok = 1'b1;
    end
    if (s_q.ok) begin
      s_d.en = 1'b1;
      // Bits 1-0 are dropped and a reserved timing field reads as the slowest code.
      s_d.prm.tr0_sel = (tr0_raw == `TBF_TIMING_RSVD) ? 2'h0 : tr0_raw;
      s_d.prm.tr1_sel = (tr1_raw == `TBF_TIMING_RSVD) ? 2'h0 : tr1_raw;
      s_d.prm.eof_omit_req = s_q.p1[3];
      s_d.prm.sof_omit_req = s_q.p1[2];
    end
  end

  tbf_crc u_crc (
    .clock(clock),
    .rstn(rstn),
    .init(crc_init),
    .step(crc_step),
    .data(crc_data),
    .crc(crc)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx = '{valid: s_q.txv, data: s_q.txd, last: s_q.txl};
  assign cmd_enabled = s_q.en;
  assign attrib_ok = s_q.ok;
  assign param1 = s_q.prm;
  assign min_tr0_fs = `TBF_MIN_TR0_FS;
  assign min_tr1_fs = `TBF_MIN_TR1_FS;
  assign sof_omit = 1'b0;
  assign eof_omit = 1'b0;
  assign busy = s_q.st != TBF_IDLE;

  // The turnaround gap after a response is the reader's duty; busy falls at the last byte.

  answer_code_a: assert property (@(posedge clock) disable iff (!rstn)
    (s_q.st == TBF_IDLE && answer_req) |=> (tx.valid && tx.data == 8'h50));
  app_zero_a: assert property (@(posedge clock) disable iff (!rstn)
    (tx.valid && s_q.idx >= 4'h5 && s_q.idx <= 4'h8) |-> tx.data == 8'h00);
  proto_one_a: assert property (@(posedge clock) disable iff (!rstn)
    (tx.valid && s_q.idx == 4'h9) |-> tx.data == 8'h91);
  proto_two_a: assert property (@(posedge clock) disable iff (!rstn)
    (tx.valid && s_q.idx == 4'hA) |-> tx.data == 8'h81);
  proto_type_a: assert property (@(posedge clock) disable iff (!rstn)
    (tx.valid && s_q.idx == 4'hA) |-> tx.data[3:0] == 4'h1);
  proto_three_a: assert property (@(posedge clock) disable iff (!rstn)
    (tx.valid && s_q.idx == 4'hB) |-> tx.data == {fwi, 4'h0});
  adc_bits_a: assert property (@(posedge clock) disable iff (!rstn)
    (tx.valid && s_q.idx == 4'hB) |-> tx.data[3:2] == 2'b00);
  fo_bits_a: assert property (@(posedge clock) disable iff (!rstn)
    (tx.valid && s_q.idx == 4'hB) |-> tx.data[1:0] == 2'b00);
  attrib_enable_a: assert property (@(posedge clock) disable iff (!rstn)
    attrib_ok |=> cmd_enabled);
  rsvd_timing_a: assert property (@(posedge clock) disable iff (!rstn)
    attrib_ok |=> (param1.tr0_sel != 2'b11 && param1.tr1_sel != 2'b11));
  fixed_timing_a: assert property (@(posedge clock) disable iff (!rstn)
    (min_tr0_fs == 8'h40 && min_tr1_fs == 8'h50 && !sof_omit && !eof_omit));
  frame_len_a: assert property (@(posedge clock) disable iff (!rstn)
    (tx.valid && tx.last && tx_ready) |-> s_q.idx == 4'hD);
  crc_gate_a: assert property (@(posedge clock) disable iff (!rstn)
    attrib_ok |-> $past(crc) == 16'hF0B8);
endmodule // tbf_framer

// *** design/tbf_pkg.sv ***
/*
  Types shared by the framer files. Assumes tbf_defines.svh beside it.
*/
package tbf_pkg;
  typedef enum logic [1:0] {
    TBF_IDLE = 2'b00,
    TBF_SEND = 2'b01,
    TBF_RECV = 2'b10
  } tbf_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } tbf_byte_t;

  typedef struct packed {
    logic [1:0] tr0_sel;
    logic [1:0] tr1_sel;
    logic eof_omit_req;
    logic sof_omit_req;
  } tbf_param1_t;
endpackage

// *** verification/tbf_framer_tb.sv ***
/*
  Self-checking bench for the answer framer and attribute parser.
  Assumes the reader model beside it drives rx and tx_ready.
*/
`timescale 1ns/100ps
module tbf_framer_tb;
  import tbf_pkg::*;
  logic clock, rstn, answer_req, tx_ready, cmd_enabled, attrib_ok, sof_omit, eof_omit, busy;
  logic [31:0] card_id;
  logic [3:0] fwi;
  tbf_byte_t rx, tx;
  tbf_param1_t param1;
  logic [7:0] min_tr0_fs, min_tr1_fs;
  logic [7:0] q[$];
  int errors, n_tests;
  tbf_framer i_dut (.clock(clock), .rstn(rstn), .card_id(card_id), .fwi(fwi), .answer_req(answer_req),
    .rx(rx), .tx(tx), .tx_ready(tx_ready), .cmd_enabled(cmd_enabled), .attrib_ok(attrib_ok),
    .param1(param1), .min_tr0_fs(min_tr0_fs), .min_tr1_fs(min_tr1_fs), .sof_omit(sof_omit),
    .eof_omit(eof_omit), .busy(busy));
  tbf_reader_model i_rdr (.clock(clock), .rstn(rstn), .tx(tx), .tx_ready(tx_ready), .rx(rx));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic close_out();
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] crc_b(input logic [7:0] b[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    end
    return ~c;
  endfunction
  function automatic tbf_param1_t p1_exp(input logic [7:0] b);
    tbf_param1_t p;
    p.tr0_sel = (b[7:6] == 2'h3) ? 2'h0 : b[7:6];
    p.tr1_sel = (b[5:4] == 2'h3) ? 2'h0 : b[5:4];
    p.eof_omit_req = b[3];
    p.sof_omit_req = b[2];
    return p;
  endfunction
  task automatic do_answer(input logic [31:0] id, input logic [3:0] f);
    logic [7:0] e[$];
    logic [15:0] c;
    e = '{8'h50, id[31:24], id[23:16], id[15:8], id[7:0], 8'h00, 8'h00, 8'h00, 8'h00, 8'h91, 8'h81, {f, 4'h0}};
    c = crc_b(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    i_rdr.got.delete();
    card_id = id;
    fwi = f;
    answer_req = 1'b1;
    @(negedge clock);
    chk("answer start", 16'h0150, {7'h00, tx.valid, tx.data});
    @(negedge clock);
    answer_req = 1'b0;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clock);
    if (busy !== 1'b0) begin
      errors++;
      close_out();
    end
    repeat (3) @(negedge clock);
    chk("answer length", 16'd14, i_rdr.got.size());
    foreach (e[i]) chk("answer byte", {7'h00, i == 13, e[i]}, (i < i_rdr.got.size()) ? {7'h00, i_rdr.got[i]} : 16'hFFFF);
  endtask
  task automatic do_attrib(input logic [7:0] code, input logic [31:0] id, input logic [7:0] p1, input logic [1:0] flt,
                           input logic ok);
    logic [15:0] c;
    q = '{code, id[31:24], id[23:16], id[15:8], id[7:0], p1, 8'h00, 8'h01, 8'h00};
    c = crc_b(q);
    q.push_back(c[7:0] ^ {7'h00, flt == 2'h2});
    if (flt != 2'h1) q.push_back(c[15:8]);
    i_rdr.send(q);
    @(negedge clock);
    chk("attrib pulse", {15'h0000, ok}, {15'h0000, attrib_ok});
    @(negedge clock);
    chk("attrib pulse end", 16'h0000, {15'h0000, attrib_ok});
    chk("cmd enabled", {15'h0000, ok}, {15'h0000, cmd_enabled});
    if (ok) chk("param1", {10'h000, p1_exp(p1)}, {10'h000, param1});
    chk("fixed timing", 16'h4050, {min_tr0_fs, min_tr1_fs});
    chk("delimiters", 16'h0000, {14'h0000, sof_omit, eof_omit});
  endtask
  initial begin
    logic [31:0] id;
    errors = 0;
    n_tests = 0;
    rstn = 1'b0;
    card_id = 32'h0000_0000;
    fwi = 4'h0;
    answer_req = 1'b0;
    void'($urandom(72));
    repeat (5) @(negedge clock);
    chk("reset outputs", 16'h0000, {13'h0000, tx.valid, cmd_enabled, busy});
    rstn = 1'b1;
    @(negedge clock);
    do_answer(32'hFFFF_FFFF, 4'h0);
    do_answer(32'h0000_0001, 4'hF);
    for (int n = 0; n < 6; n++) do_answer($urandom(), 4'($urandom_range(15)));
    id = $urandom();
    do_answer(id, 4'h4);
    do_attrib(8'h1D, ~id, 8'hFC, 2'h0, 1'b0);
    do_attrib(8'h05, id, 8'h00, 2'h0, 1'b0);
    do_attrib(8'h1D, id, 8'h00, 2'h1, 1'b0);
    do_attrib(8'h1D, id, 8'h00, 2'h2, 1'b0);
    for (int n = 0; n < 16; n++) begin
      do_attrib(8'h1D, id, {4'(n), 4'($urandom_range(15))}, 2'h0, 1'b1);
    end
    close_out();
  end
endmodule // tbf_framer_tb

// *** verification/tbf_reader_model.sv ***
/*
  Reader-side model: sinks answer bytes with random stalls and sends command
  frames. Assumes the bench seeds randomness and calls send from one thread.
*/
`timescale 1ns/100ps
module tbf_reader_model
  import tbf_pkg::*;
#(
  // Cycles for 10 etu plus 32 subcarrier periods at 20 MHz; rounded down.
  parameter int TURN_CYC = 2643
)(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Answer stream from the tag
  input wire tbf_byte_t tx,
  output logic tx_ready,
  // Command stream to the tag
  output tbf_byte_t rx
);
  logic [8:0] got[$];
  int quiet;
  logic sending;
  initial begin
    rx = '0;
    tx_ready = 1'b0;
    sending = 1'b0;
    quiet = TURN_CYC;
  end
  always @(negedge clock) tx_ready <= ($urandom_range(99) >= 30);
  // An idle command line keeps changing so stale bytes cannot look valid.
  always @(negedge clock) if (!sending) begin
    rx.valid <= 1'b0;
    rx.last <= 1'b0;
    rx.data <= ~rx.data;
  end
  always @(posedge clock) begin
    if (rstn && tx.valid && tx_ready) begin
      got.push_back({tx.last, tx.data});
    end
    if (rstn && tx.valid && tx_ready && tx.last) quiet <= 0;
    else if (quiet < TURN_CYC) quiet <= quiet + 1;
  end
  task automatic send(input logic [7:0] b[$]);
    for (int i = 0; i < TURN_CYC && quiet < TURN_CYC; i++) @(negedge clock);
    sending = 1'b1;
    foreach (b[i]) begin
      @(negedge clock);
      rx <= '{1'b1, b[i], i == b.size() - 1};
    end
    @(negedge clock);
    rx.valid <= 1'b0;
    rx.last <= 1'b0;
    sending = 1'b0;
  endtask
endmodule // tbf_reader_model
